// *** srp_core.sv ***
// Behaviour
// - system reset full; disable does partial reset
// - disable keeps control bits and error flags
// - master mode fault clears module enable
// - keeps running in wait; requests wake cpu
// - registers closed to cpu during wait
// - stop freezes core and baud divider, resumes after stop; synchroniser keeps sampling
// - reset out of stop aborts transfer
// - protected break freezes flags; second step still drops the arm
// - unprotected break clears stick afterwards
// - protected break data write does nothing
// - wired-or makes mosi open drain; miso stays push-pull
// - slave-out driven only when slave selected
// - deselected slave ignores serial clock edges
// - enabled block owns data and clock pins
// - master drives clock; eight bits duplex
// - cpha0 slave starts on select falling
// - select pin owned per mode and enable
// - master watches select for mode fault
// - slave select always input; fault maskable
// - three registers at consecutive indices
// - mode fault on slave rise, master low
// - baud select divides bus clock in master
// - transmit empty set on shift load
`timescale 1ns/10ps
`default_nettype none
module srp_core
  import srp_pkg::*;
(
  // clock, reset and clock enable
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    clk_en,
  // apb slave
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [srp_pkg::APB_AW-1:0] paddr,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  // system state
  input  wire logic                    wait_mode,
  input  wire logic                    stop_mode,
  input  wire logic                    debug_break,
  input  wire logic                    break_clear_enable,
  output logic                         wake_request,
  // pin ownership toward the shared port
  output logic                         pins_owned,
  output logic                         ss_gpio,
  // serial pins
  input  wire logic                    serial_clock_pin_in,
  output logic                         serial_clock_pin_out,
  output logic                         serial_clock_pin_oe,
  input  wire logic                    mosi_in,
  output logic                         mosi_out,
  output logic                         mosi_oe,
  input  wire logic                    miso_in,
  output logic                         miso_out,
  output logic                         miso_oe,
  input  wire logic                    ss_n_in
);
  typedef struct packed {
    logic [7:0]  ctrl;
    logic        err_irq_en;
    logic        mode_fault_enable;
    logic [1:0]  baud;
    logic        rx_full;
    logic        overflow;
    logic        mode_fault;
    logic        tx_empty;
    logic        ovr_arm;
    logic        mf_arm;
    logic [7:0]  tx_buf;
    logic [7:0]  rx_data;
    logic [7:0]  shift;
    logic        out_bit;
    logic        busy;
    logic [3:0]  cnt;
    logic        sck;
    logic        sck_prev;
    logic        ss_prev;
    logic [7:0]  rdata;
    logic        irq;
  } srp_core_type;
  srp_core_type st_q, st_d;

  srp_baud_if baud_if ();
  logic [3:0] pins_s;
  logic       sck_s, mosi_s, miso_s, ss_s;
  logic       run, en, master, cpol, cpha, protect;
  logic       setup, access, hit_ctrl, hit_stat, hit_data, hit;
  logic       wr_ctrl, wr_stat, wr_data, rd_stat, rd_data;
  logic       sck_edge, load, leading, edge_now, mf_master;

  // every serial input is synchronised before use
  srp_sync #(.WIDTH(4)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .clk_en  (clk_en),
    .d       ({serial_clock_pin_in, mosi_in, miso_in, ss_n_in}),
    .q       (pins_s)
  );
  assign {sck_s, mosi_s, miso_s, ss_s} = pins_s;

  srp_baud u_baud (
    .pclk    (pclk),
    .presetn (presetn),
    .clk_en  (run),
    .baud    (baud_if)
  );
  assign baud_if.run = en && master && st_q.busy;
  assign baud_if.sel = st_q.baud;

  // stop mode and clock enable freeze core and divider state; the synchroniser stops on clock enable only
  assign run     = clk_en && !stop_mode;
  assign en      = st_q.ctrl[CTL_MODULE_ENABLE];
  assign master  = st_q.ctrl[CTL_MASTER_SELECT];
  assign cpol    = st_q.ctrl[CTL_CPOL];
  assign cpha    = st_q.ctrl[CTL_CPHA];
  // flags locked while break is protected
  assign protect = debug_break && !break_clear_enable;

  // apb decode; three consecutive register slots
  assign setup    = psel && !penable;
  assign access   = psel && penable && run;
  assign hit_ctrl = paddr == REG_CTRL_ADDR;
  assign hit_stat = paddr == REG_STAT_ADDR;
  assign hit_data = paddr == REG_DATA_ADDR;
  assign hit      = hit_ctrl || hit_stat || hit_data;
  // no register effect while the cpu waits
  assign wr_ctrl  = access && pwrite && !wait_mode && hit_ctrl;
  assign wr_stat  = access && pwrite && !wait_mode && hit_stat;
  assign wr_data  = access && pwrite && !wait_mode && hit_data;
  assign rd_stat  = access && !pwrite && !wait_mode && hit_stat;
  assign rd_data  = access && !pwrite && !wait_mode && hit_data;
  assign pready   = psel && penable && run;
  assign pslverr  = pready && (!hit || wait_mode);
  assign prdata   = {24'h000000, st_q.rdata};

  // serial clock edge events for master and slave
  // a deselected slave sees no edges at all
  assign sck_edge = en && !master && !ss_s && (sck_s != st_q.sck_prev);
  assign edge_now = (en && master && st_q.busy && baud_if.tick) ||
                    (sck_edge && st_q.busy);
  assign leading  = master ? (st_q.sck == cpol) : (sck_s != cpol);
  // master watches select when fault detection is on
  assign mf_master = en && master && st_q.mode_fault_enable && !ss_s;

  // transfer start: master when data queued, slave on select or edge
  // cpha0 slave begins at the falling select edge
  always_comb begin
    if (!en || st_q.busy) begin
      load = 1'b0;
    end else if (master) begin
      load = !st_q.tx_empty;
    end else if (!cpha) begin
      load = st_q.ss_prev && !ss_s;
    end else begin
      load = sck_edge;
    end
  end

  // next state of the whole block
  always_comb begin
    logic [7:0] src;
    logic       rx_in;
    logic       sample;
    src    = st_q.tx_empty ? st_q.shift : st_q.tx_buf;
    rx_in  = master ? miso_s : mosi_s;
    sample = leading ^ cpha;
    st_d   = st_q;
    if (run) begin
      st_d.sck_prev = sck_s;
      st_d.ss_prev  = ss_s;
      // read data is captured in the setup phase
      if (setup) begin
        case (1'b1)
          hit_ctrl: st_d.rdata = st_q.ctrl & CTL_WRITE_MASK;
          hit_stat: st_d.rdata = {st_q.rx_full, st_q.err_irq_en,
                                  st_q.overflow, st_q.mode_fault,
                                  st_q.tx_empty, st_q.mode_fault_enable,
                                  st_q.baud};
          hit_data: st_d.rdata = st_q.rx_data;
          default:  st_d.rdata = 8'h00;
        endcase
      end
      // byte-wide registers, upper bus bits ignored
      if (wr_ctrl) begin
        st_d.ctrl = pwdata[7:0] & CTL_WRITE_MASK;
        // second clearing step of the mode fault
        if (st_q.mf_arm && !protect) begin
          st_d.mode_fault = 1'b0;
        end
        st_d.mf_arm = 1'b0;
      end
      if (wr_stat) begin
        st_d.err_irq_en        = pwdata[STS_ERR_IRQ_EN];
        st_d.mode_fault_enable = pwdata[STS_MODE_FAULT_EN];
        st_d.baud = {pwdata[STS_BAUD_HI], pwdata[STS_BAUD_LO]};
      end
      // protected break: data write is dropped
      if (wr_data && !protect) begin
        st_d.tx_buf   = pwdata[7:0];
        st_d.tx_empty = 1'b0;
      end
      // first step arms the flag even inside a break
      if (rd_stat) begin
        st_d.ovr_arm = st_q.rdata[STS_OVERFLOW];
        st_d.mf_arm  = st_q.rdata[STS_MODE_FAULT];
      end
      if (rd_data) begin
        if (!protect) begin
          st_d.rx_full = 1'b0;
          if (st_q.ovr_arm) begin
            st_d.overflow = 1'b0;
          end
        end
        st_d.ovr_arm = 1'b0;
      end
      // handing the byte to the shifter empties the buffer
      if (load) begin
        st_d.shift    = src;
        st_d.out_bit  = src[7];
        st_d.busy     = 1'b1;
        st_d.tx_empty = 1'b1;
        st_d.cnt      = (!master && cpha) ? 4'h1 : 4'h0;
      end else if (edge_now) begin
        if (master) begin
          st_d.sck = !st_q.sck;
        end
        // sample edges shift in, the other edges present the next bit
        if (sample) begin
          st_d.shift = {st_q.shift[6:0], rx_in};
        end else begin
          st_d.out_bit = st_q.shift[7];
        end
        st_d.cnt = st_q.cnt + 4'h1;
        if (st_q.cnt == LAST_EDGE) begin
          st_d.busy = 1'b0;
          st_d.cnt  = 4'h0;
          // overflow keeps the old byte, the new one is lost
          if (st_q.rx_full) begin
            st_d.overflow = 1'b1;
          end else begin
            st_d.rx_full = 1'b1;
            st_d.rx_data = st_d.shift;
          end
        end
      end
      // slave select rising mid transfer is a mode fault
      if (en && !master && st_q.mode_fault_enable && st_q.busy &&
          !st_q.ss_prev && ss_s) begin
        st_d.mode_fault = 1'b1;
      end
      // master mode fault disables the block
      if (mf_master) begin
        st_d.mode_fault                  = 1'b1;
        st_d.ctrl[CTL_MODULE_ENABLE]     = 1'b0;
      end
      // partial reset whenever the block is disabled
      // control bits and error flags are left alone
      if (!st_d.ctrl[CTL_MODULE_ENABLE]) begin
        st_d.tx_empty = 1'b1;
        st_d.busy     = 1'b0;
        st_d.shift    = 8'h00;
        st_d.cnt      = 4'h0;
        st_d.out_bit  = 1'b0;
        st_d.sck      = st_d.ctrl[CTL_CPOL];
      end else if (!st_q.busy && !load) begin
        st_d.sck = st_d.ctrl[CTL_CPOL];
      end
      // any enabled request can wake the cpu from wait
      st_d.irq = (st_d.ctrl[CTL_TX_IRQ_EN] && st_d.tx_empty) ||
                 (st_d.ctrl[CTL_RX_IRQ_EN] && st_d.rx_full) ||
                 (st_d.err_irq_en && (st_d.overflow || st_d.mode_fault));
    end
  end

  // reset during stop lands here and loads reset values; ctrl to CTL_RESET, transmit empty set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q          <= '0;
      st_q.ctrl     <= CTL_RESET;
      st_q.tx_empty <= 1'b1;
      st_q.ss_prev  <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  assign wake_request = st_q.irq;

  // enabled block owns clock and data pins
  // select pin is general purpose unless watched
  // a slave always takes select as input
  assign pins_owned = en;
  assign ss_gpio    = !en || (master && !st_q.mode_fault_enable);

  // only the master drives the serial clock
  assign serial_clock_pin_out = st_q.sck;
  assign serial_clock_pin_oe  = en && master;
  // wired-or: drive only the low level
  assign mosi_out = st_q.ctrl[CTL_WIRED_OR] ? 1'b0 : st_q.out_bit;
  assign mosi_oe  = en && master &&
                    (!st_q.ctrl[CTL_WIRED_OR] || !st_q.out_bit);
  assign miso_out = st_q.out_bit;
  assign miso_oe  = en && !master && !ss_s;

  // assertions
  // partial reset state
  AST_PARTIAL_RESET: assert property (@(posedge pclk) disable iff (!presetn)
    !en |-> st_q.tx_empty && !st_q.busy && st_q.shift == 8'h00)
    else $error("disabled block not in partial reset");
  AST_FLAGS_KEPT: assert property (@(posedge pclk) disable iff (!presetn)
    run && !en && !rd_data && !wr_ctrl && !wr_stat |=>
      $stable(st_q.rx_full) && $stable(st_q.overflow) &&
      $stable(st_q.mode_fault) && $stable(st_q.baud))
    else $error("flag changed while disabled");
  AST_MODE_FAULT_FLAG_DISABLE: assert property (@(posedge pclk) disable iff (!presetn)
    run && mf_master |=> !en && st_q.mode_fault && st_q.tx_empty)
    else $error("master mode fault did not disable");
  AST_WAIT_NOWRITE: assert property (@(posedge pclk) disable iff (!presetn)
    access && pwrite && wait_mode && !mf_master |=>
      $stable(st_q.ctrl) && $stable(st_q.tx_buf))
    else $error("register written during wait");
  AST_STOP_FREEZE: assert property (@(posedge pclk) disable iff (!presetn)
    stop_mode |=> st_q == $past(st_q))
    else $error("state moved in stop mode");
  AST_BREAK_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
    wr_data && protect && run |=> $stable(st_q.tx_buf))
    else $error("data write took effect in protected break");
  AST_MISO_OE: assert property (@(posedge pclk) disable iff (!presetn)
    miso_oe |-> en && !master && !ss_s && !serial_clock_pin_oe)
    else $error("slave output driven while not selected");
  AST_SLAVE_IGNORE: assert property (@(posedge pclk) disable iff (!presetn)
    run && en && !master && ss_s && st_q.busy && $stable(st_q.ctrl) |=>
      $stable(st_q.cnt) && $stable(st_q.shift))
    else $error("deselected slave moved on a clock edge");
  // divide by two toggles every bus clock
  AST_BAUD_DIV2: assert property (@(posedge pclk) disable iff (!presetn)
    run && en && master && st_q.busy && st_q.baud == 2'b00 && !mf_master
      && !wr_ctrl |=> st_q.sck != $past(st_q.sck))
    else $error("divide by two clock did not toggle");
  AST_TXE_ON_LOAD: assert property (@(posedge pclk) disable iff (!presetn)
    run && load |=> st_q.tx_empty && st_q.busy && st_q.cnt <= 4'h1)
    else $error("shift load did not set transmit empty");
endmodule : srp_core
`default_nettype wire

// *** srp_pkg.sv ***
`default_nettype none
package srp_pkg;
  // register indices; the byte address is four times the index
  localparam logic [7:0] REG_CTRL_IDX   = 8'h10;
  localparam logic [7:0] REG_STAT_IDX   = 8'h11;
  localparam logic [7:0] REG_DATA_IDX   = 8'h12;
  localparam logic [7:0] REG_CTRL_ADDR  = {REG_CTRL_IDX[5:0], 2'b00};
  localparam logic [7:0] REG_STAT_ADDR  = {REG_STAT_IDX[5:0], 2'b00};
  localparam logic [7:0] REG_DATA_ADDR  = {REG_DATA_IDX[5:0], 2'b00};
  localparam int         APB_AW         = 8;

  // serial_control field positions
  localparam int CTL_RX_IRQ_EN     = 7;
  localparam int CTL_MASTER_SELECT = 5;
  localparam int CTL_CPOL          = 4;
  localparam int CTL_CPHA          = 3;
  localparam int CTL_WIRED_OR      = 2;
  localparam int CTL_MODULE_ENABLE = 1;
  localparam int CTL_TX_IRQ_EN     = 0;
  localparam logic [7:0] CTL_WRITE_MASK = 8'hbf;  // bit 6 reserved
  localparam logic [7:0] CTL_RESET      = 8'h28;  // master, cpha set

  // serial_status_control field positions
  localparam int STS_RX_FULL       = 7;
  localparam int STS_ERR_IRQ_EN    = 6;
  localparam int STS_OVERFLOW      = 5;
  localparam int STS_MODE_FAULT    = 4;
  localparam int STS_TX_EMPTY      = 3;
  localparam int STS_MODE_FAULT_EN = 2;
  localparam int STS_BAUD_HI       = 1;
  localparam int STS_BAUD_LO       = 0;

  // bus clock divisors per baud select code
  localparam int BAUD_DIV_00 = 2;
  localparam int BAUD_DIV_01 = 8;
  localparam int BAUD_DIV_10 = 32;
  localparam int BAUD_DIV_11 = 128;

  // one byte is sixteen serial clock edges
  localparam int          BITS_PER_BYTE = 8;
  localparam logic [3:0]  LAST_EDGE     = 4'hf;
endpackage : srp_pkg
`default_nettype wire

// *** srp_baud_if.sv ***
`timescale 1ns/10ps
`default_nettype none
// baud tick request and answer between core and divider
interface srp_baud_if;
  logic       run;
  logic [1:0] sel;
  logic       tick;
  modport core (output run, output sel, input tick);
  modport gen  (input run, input sel, output tick);
endinterface : srp_baud_if
`default_nettype wire

// *** srp_sync.sv ***
`timescale 1ns/10ps
`default_nettype none
module srp_sync #(
  parameter int WIDTH = 4
) (
  // clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             clk_en,
  // pins in, synchronised levels out
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } srp_sync_type;
  srp_sync_type st_q, st_d;

  initial begin
    if (WIDTH < 1) $error("srp_sync needs at least one bit");
  end

  // first stage feeds only the second stage
  always_comb begin
    st_d = st_q;
    if (clk_en) begin
      st_d.s1 = d;
      st_d.s2 = st_q.s1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign q = st_q.s2;
endmodule : srp_sync
`default_nettype wire

// *** srp_baud.sv ***
`timescale 1ns/10ps
`default_nettype none
module srp_baud
  import srp_pkg::*;
#(
  parameter int DIV_00 = srp_pkg::BAUD_DIV_00,
  parameter int DIV_01 = srp_pkg::BAUD_DIV_01,
  parameter int DIV_10 = srp_pkg::BAUD_DIV_10,
  parameter int DIV_11 = srp_pkg::BAUD_DIV_11
) (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic clk_en,
  // tick toward the core
  srp_baud_if.gen   baud
);
  typedef struct packed {
    logic [6:0] cnt;
  } srp_baud_type;
  srp_baud_type st_q, st_d;
  logic [6:0]   half_m1;

  initial begin
    if (DIV_00 < 2 || DIV_01 < 2 || DIV_10 < 2 || DIV_11 < 2 ||
        DIV_00 % 2 != 0 || DIV_01 % 2 != 0 || DIV_10 % 2 != 0 ||
        DIV_11 % 2 != 0 || DIV_11 > 256)
      $error("srp_baud divisors must be even and in 2..256");
  end

  // one tick per half serial clock period
  always_comb begin
    case (baud.sel)
      2'b00:   half_m1 = 7'(DIV_00 / 2 - 1);
      2'b01:   half_m1 = 7'(DIV_01 / 2 - 1);
      2'b10:   half_m1 = 7'(DIV_10 / 2 - 1);
      default: half_m1 = 7'(DIV_11 / 2 - 1);
    endcase
  end

  // counter restarts whenever the core stops asking
  always_comb begin
    st_d = st_q;
    if (clk_en) begin
      if (!baud.run || st_q.cnt >= half_m1) begin
        st_d.cnt = '0;
      end else begin
        st_d.cnt = st_q.cnt + 7'h01;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign baud.tick = baud.run && (st_q.cnt >= half_m1);
endmodule : srp_baud
`default_nettype wire

// *** srp_peer.sv ***
`timescale 1ns/10ps
`default_nettype none
// serial slave on the far side of a master: cpol 0, cpha 1, msb first
module srp_peer (
  // serial pins
  input  wire logic       sck,
  input  wire logic       mosi,
  output logic            miso,
  // byte to answer with, byte seen
  input  wire logic [7:0] tx_byte,
  output logic [7:0]      rx_byte
);
  logic [2:0] cnt;

  initial begin
    cnt     = 3'h0;
    miso    = 1'b1;
    rx_byte = 8'h00;
  end

  always @(posedge sck) begin
    miso <= tx_byte[3'h7 - cnt];
  end

  // trailing edge samples; frame of eight
  always @(negedge sck) begin
    rx_byte <= {rx_byte[6:0], mosi};
    cnt     <= cnt + 3'h1;
    // hold ends here, so the line flips rather than keep the last bit
    if (cnt == 3'h7) begin
      miso <= ~miso;
    end
  end
endmodule : srp_peer
`default_nettype wire

// *** tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import srp_pkg::*;
  // bus side
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  // system and pins
  logic        wait_mode, debug_break, wake_request, pins_owned, ss_gpio;
  logic        stop_mode, bce;
  logic        sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe;
  logic        sck_tb, ss_n, peer_miso, err;
  logic [7:0]  peer_rx, rd;
  int          error_cnt, checks_done, cyc;
  // released lines: clock from bench, data out pulled up
  wire logic   sck_w  = sck_oe ? sck_out : sck_tb;
  wire logic   mosi_w = mosi_oe ? mosi_out : 1'b1;
  wire logic   miso_w = miso_oe ? miso_out : peer_miso;

  srp_core i_dut (.pclk(pclk), .presetn(presetn), .clk_en(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .wait_mode(wait_mode), .stop_mode(stop_mode), .debug_break(debug_break),
    .break_clear_enable(bce), .wake_request(wake_request),
    .pins_owned(pins_owned), .ss_gpio(ss_gpio),
    .serial_clock_pin_in(sck_w), .serial_clock_pin_out(sck_out),
    .serial_clock_pin_oe(sck_oe), .mosi_in(mosi_w), .mosi_out(mosi_out),
    .mosi_oe(mosi_oe), .miso_in(miso_w), .miso_out(miso_out),
    .miso_oe(miso_oe), .ss_n_in(ss_n));

  srp_peer i_peer (.sck(sck_w), .mosi(mosi_w), .miso(peer_miso),
    .tx_byte(8'h3c), .rx_byte(peer_rx));

  // 40 MHz bus clock
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // cut a hang short
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      end_sim();
    end
  end

  task automatic end_sim;
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // one apb transfer; waits for pready, no wait count assumed
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata[7:0];
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // let the register update of the access edge settle before callers look
    @(negedge pclk);
  endtask : apb

  task automatic rdc(input string n, input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    chk(n, e, rd);
  endtask : rdc

  task automatic t_reset;
    rdc("ctrl", REG_CTRL_ADDR, 8'h28);    // control reset
    rdc("status", REG_STAT_ADDR, 8'h08);  // status reset
    rdc("data", REG_DATA_ADDR, 8'h00);    // data reset
    rdc("hole", 8'h00, 8'h00);            // hole reads zero
    chk("hole_err", 8'h01, {7'h00, err}); // hole refused
  endtask : t_reset

  task automatic t_xfer;
    int n;
    apb(1'b1, REG_STAT_ADDR, 8'h01);
    apb(1'b1, REG_CTRL_ADDR, 8'h2a);
    chk("owned", 8'h01, {7'h00, pins_owned}); // pins taken
    chk("sck_oe", 8'h01, {7'h00, sck_oe});    // master drives clock
    apb(1'b1, REG_DATA_ADDR, 8'ha5);
    n = 0;
    while (sck_w === 1'b0 && n < 50) begin
      @(posedge pclk);
      n++;
    end
    n = 0;
    while (sck_w === 1'b1 && n < 50) begin
      @(posedge pclk);
      n++;
    end
    chk("half_period", 8'h04, n[7:0]); // divide by eight
    // a running clock would have risen again by the sixth edge
    stop_mode <= 1'b1;
    repeat (6) @(posedge pclk);
    chk("stop_sck", 8'h00, {7'h00, sck_w}); // clock frozen in stop
    stop_mode <= 1'b0;
    n = 0;
    do begin
      apb(1'b0, REG_STAT_ADDR, 8'h00);
      n++;
    end while (rd[7] !== 1'b1 && n < 40);
    chk("tx_empty", 8'h08, rd & 8'h08);        // empty after load
    chk("peer_rx", 8'ha5, peer_rx);            // msb first out
    rdc("rx_data", REG_DATA_ADDR, 8'h3c);      // byte in
    // fastest divisor; only the outgoing byte is judged here
    apb(1'b1, REG_STAT_ADDR, 8'h00);
    apb(1'b1, REG_DATA_ADDR, 8'h5a);
    repeat (30) @(posedge pclk);
    chk("peer_rx2", 8'h5a, peer_rx);           // divide by two
    apb(1'b1, REG_STAT_ADDR, 8'h01);
    apb(1'b0, REG_DATA_ADDR, 8'h00);
  endtask : t_xfer

  task automatic t_partial;
    apb(1'b1, REG_CTRL_ADDR, 8'ha9);
    rdc("ctrl_kept", REG_CTRL_ADDR, 8'ha9);        // control kept
    chk("owned_off", 8'h00, {7'h00, pins_owned});  // pins given back
    rdc("stat_kept", REG_STAT_ADDR, 8'h09);        // empty, baud kept
    repeat (2) @(posedge pclk);
    chk("wake_on", 8'h01, {7'h00, wake_request});  // request wakes
    apb(1'b1, REG_CTRL_ADDR, 8'h28);
    repeat (2) @(posedge pclk);
    chk("wake_off", 8'h00, {7'h00, wake_request}); // masked again
  endtask : t_partial

  task automatic t_wait;
    @(posedge pclk);
    wait_mode <= 1'b1;
    apb(1'b1, REG_CTRL_ADDR, 8'h2a);
    chk("wait_wr", 8'h01, {7'h00, err}); // write shut out
    apb(1'b0, REG_CTRL_ADDR, 8'h00);
    chk("wait_rd", 8'h01, {7'h00, err}); // read shut out
    @(posedge pclk);
    wait_mode <= 1'b0;
    rdc("ctrl_same", REG_CTRL_ADDR, 8'h28); // write had no effect
  endtask : t_wait

  task automatic t_break;
    apb(1'b1, REG_CTRL_ADDR, 8'h2a);
    @(posedge pclk);
    debug_break <= 1'b1;
    apb(1'b1, REG_DATA_ADDR, 8'h55);
    repeat (10) @(posedge pclk);
    chk("brk_sck", 8'h00, {7'h00, sck_w});  // no transfer
    rdc("brk_stat", REG_STAT_ADDR, 8'h09);  // still empty
    @(posedge pclk);
    debug_break <= 1'b0;
    apb(1'b1, REG_CTRL_ADDR, 8'h28);
  endtask : t_break

  task automatic t_fault;
    apb(1'b1, REG_STAT_ADDR, 8'h05);
    apb(1'b1, REG_CTRL_ADDR, 8'h2a);
    chk("ss_in", 8'h00, {7'h00, ss_gpio});   // select is input
    @(posedge pclk);
    ss_n <= 1'b0;
    repeat (6) @(posedge pclk);
    rdc("fault_ctrl", REG_CTRL_ADDR, 8'h28); // enable dropped
    rdc("fault_stat", REG_STAT_ADDR, 8'h1d); // fault flagged
    @(posedge pclk);
    ss_n        <= 1'b1;
    debug_break <= 1'b1;
    apb(1'b1, REG_CTRL_ADDR, 8'h28);
    rdc("brk_keep", REG_STAT_ADDR, 8'h1d);   // flag frozen in break
    @(posedge pclk);
    bce <= 1'b1;
    apb(1'b1, REG_CTRL_ADDR, 8'h28);
    @(posedge pclk);
    debug_break <= 1'b0;
    bce         <= 1'b0;
    apb(1'b1, REG_STAT_ADDR, 8'h01);
    apb(1'b1, REG_CTRL_ADDR, 8'h2a);
    chk("ss_gp", 8'h01, {7'h00, ss_gpio});   // master without fault
    apb(1'b1, REG_CTRL_ADDR, 8'h28);
    rdc("stat_clr", REG_STAT_ADDR, 8'h09);   // fault cleared
  endtask : t_fault

  task automatic t_slave;
    apb(1'b1, REG_CTRL_ADDR, 8'h02);
    chk("slv_ss", 8'h00, {7'h00, ss_gpio});    // select always input
    chk("miso_hiz", 8'h00, {7'h00, miso_oe});  // deselected quiet
    // clock edges while deselected must be ignored
    repeat (16) begin
      repeat (4) @(posedge pclk);
      sck_tb <= ~sck_tb;
    end
    rdc("slv_stat", REG_STAT_ADDR, 8'h09);     // nothing received
    @(posedge pclk);
    ss_n <= 1'b0;
    repeat (4) @(posedge pclk);
    chk("miso_on", 8'h01, {7'h00, miso_oe});   // selected drives
    ss_n <= 1'b1;
    repeat (4) @(posedge pclk);
    chk("miso_off", 8'h00, {7'h00, miso_oe});  // released again
    apb(1'b1, REG_CTRL_ADDR, 8'h28);
  endtask : t_slave

  // reset arriving during stop with a byte one serial clock edge into its shift
  task automatic t_stop_rst;
    apb(1'b1, REG_CTRL_ADDR, 8'h2a);
    apb(1'b1, REG_DATA_ADDR, 8'h11);
    repeat (8) @(posedge pclk);
    stop_mode <= 1'b1;
    repeat (2) @(posedge pclk);
    presetn   <= 1'b0;
    stop_mode <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdc("rst_stat", REG_STAT_ADDR, 8'h08);  // full reset, baud cleared
    rdc("rst_ctrl", REG_CTRL_ADDR, 8'h28);  // transfer aborted
    chk("rst_sck_oe", 8'h00, {7'h00, sck_oe}); // pins released
  endtask : t_stop_rst

  // main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    wait_mode = 1'b0;
    debug_break = 1'b0;
    stop_mode = 1'b0;
    bce = 1'b0;
    sck_tb = 1'b0;
    ss_n = 1'b1;
    error_cnt = 0;
    checks_done = 0;
    cyc = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_xfer();
    t_partial();
    t_wait();
    t_break();
    t_fault();
    t_slave();
    t_stop_rst();
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
